// ==== hdl/cmpc_params.svh ====
`ifndef CMPC_PARAMS_SVH
`define CMPC_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define CMPC_ADDR_CONTROL    4'h0
`define CMPC_ADDR_FLAG       4'h1
`define CMPC_ADDR_PORT       4'h2
`define CMPC_ADDR_SLEEP      4'h3

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CMPC_BIT_PIN_SEL     7
`define CMPC_BIT_POWER       6
`define CMPC_BIT_POLARITY    5
`define CMPC_BIT_RESULT      4
`define CMPC_BIT_PATH        3
`define CMPC_BIT_EDGE_HI     2
`define CMPC_BIT_EDGE_LO     1
`define CMPC_BIT_HYST        0
`define CMPC_CONTROL_RESET   8'h81
`define CMPC_CONTROL_WMASK   8'hEF

// ----------------------------------------------------------------
// Reset values per field
// ----------------------------------------------------------------
`define CMPC_RST_PIN_SEL     1'h1
`define CMPC_RST_POWER       1'h0
`define CMPC_RST_POLARITY    1'h0
`define CMPC_RST_RESULT      1'h0
`define CMPC_RST_PATH        1'h0
`define CMPC_RST_EDGE        2'h0
`define CMPC_RST_HYST        1'h1
`define CMPC_RST_FLAG        1'h0
`define CMPC_RST_ENABLE      1'h0
`define CMPC_RST_PIN_OUT     1'h0
`define CMPC_RST_PIN_OE_N    1'h1
`define CMPC_RST_RDATA       8'h00

// ----------------------------------------------------------------
// Flag register fields
// ----------------------------------------------------------------
`define CMPC_BIT_FLAG        0
`define CMPC_BIT_ENABLE      1

// ----------------------------------------------------------------
// Shared pins: two comparator inputs
// ----------------------------------------------------------------
`define CMPC_PIN_COUNT       2

`endif

// ==== hdl/cmpc_pkg.sv ====
package cmpc_pkg;

  typedef enum logic [1:0] {
    CMPC_EDGE_RISE = 2'b00,
    CMPC_EDGE_FALL = 2'b01,
    CMPC_EDGE_BOTH = 2'b10,
    CMPC_EDGE_ANY  = 2'b11
  } cmpc_edge_t;

endpackage

// ==== hdl/cmpc_sync.sv ====
`timescale 1ns/1ps

module cmpc_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage_a;
  logic stage_b;
  logic stage_c;

  // ----------------------------------------------------------------
  // Three stages, change accepted once the last two agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_a <= 1'b0;
      stage_b <= 1'b0;
      stage_c <= 1'b0;
    end else begin
      stage_a <= async_in;
      stage_b <= stage_a;
      stage_c <= stage_b;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_out <= 1'b0;
    end else if (stage_b == stage_c) begin
      sync_out <= stage_c;
    end
  end

endmodule // cmpc_sync

// ==== hdl/cmpc_top.sv ====
`timescale 1ns/1ps
`include "cmpc_params.svh"

module cmpc_top (
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic [3:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [7:0]                  reg_rdata,
  input  wire logic                        analog_compare,
  output logic                             analog_power_on,
  output logic                             analog_hysteresis_on,
  output logic                             analog_inputs_connect,
  input  wire logic [`CMPC_PIN_COUNT-1:0]  port_data,
  input  wire logic [`CMPC_PIN_COUNT-1:0]  port_control,
  input  wire logic [`CMPC_PIN_COUNT-1:0]  pull_high_request,
  output logic      [`CMPC_PIN_COUNT-1:0]  pull_high_enable,
  output logic      [`CMPC_PIN_COUNT-1:0]  port_function_enable,
  output logic                             compare_output_pin_o,
  output logic                             compare_output_pin_oe_n,
  input  wire logic                        low_power_mode,
  output logic                             irq_request,
  output logic                             wake_request
);

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  logic                        input_pin_select;
  logic                        comparator_power_on;
  logic                        output_polarity;
  logic                        compare_result;
  logic                        output_path_select;
  cmpc_pkg::cmpc_edge_t        irq_edge_select;
  logic                        hysteresis_on;
  logic                        irq_flag;
  logic                        irq_enable;
  logic                        raw_sync;
  logic                        result_prev;
  logic                        rise_seen;
  logic                        fall_seen;
  logic                        edge_hit;
  logic                        ctrl_write;
  logic                        flag_write;
  logic [7:0]                  control_value;
  logic [`CMPC_PIN_COUNT-1:0]  port_view;
  logic [7:0]                  next_rdata;

  assign ctrl_write = reg_write && (reg_addr == `CMPC_ADDR_CONTROL);
  assign flag_write = reg_write && (reg_addr == `CMPC_ADDR_FLAG);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Result bit has no storage here; software writes to it are dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      input_pin_select <= `CMPC_RST_PIN_SEL;
    end else if (ctrl_write) begin
      input_pin_select <= reg_wdata[`CMPC_BIT_PIN_SEL];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      comparator_power_on <= `CMPC_RST_POWER;
    end else if (ctrl_write) begin
      comparator_power_on <= reg_wdata[`CMPC_BIT_POWER];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      output_polarity <= `CMPC_RST_POLARITY;
    end else if (ctrl_write) begin
      output_polarity <= reg_wdata[`CMPC_BIT_POLARITY];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      output_path_select <= `CMPC_RST_PATH;
    end else if (ctrl_write) begin
      output_path_select <= reg_wdata[`CMPC_BIT_PATH];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_edge_select <= cmpc_pkg::cmpc_edge_t'(`CMPC_RST_EDGE);
    end else if (ctrl_write) begin
      irq_edge_select <= cmpc_pkg::cmpc_edge_t'(reg_wdata[`CMPC_BIT_EDGE_HI:`CMPC_BIT_EDGE_LO]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hysteresis_on <= `CMPC_RST_HYST;
    end else if (ctrl_write) begin
      hysteresis_on <= reg_wdata[`CMPC_BIT_HYST];
    end
  end

  // ----------------------------------------------------------------
  // Analog core controls
  // ----------------------------------------------------------------
  assign analog_power_on       = comparator_power_on;
  assign analog_hysteresis_on  = hysteresis_on;
  assign analog_inputs_connect = input_pin_select;

  // ----------------------------------------------------------------
  // Shared pins, one generate per pin
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CMPC_PIN_COUNT; gi++) begin : g_pin
      assign port_function_enable[gi] = ~input_pin_select;
      assign pull_high_enable[gi] = pull_high_request[gi] & ~input_pin_select;
      // Comparator enabled means both selected and powered
      assign port_view[gi] = (input_pin_select && comparator_power_on) ?
                             (port_control[gi] ? 1'b0 : port_data[gi]) : port_data[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Result path
  // ----------------------------------------------------------------
  // Analog output is asynchronous to clk_sys
  cmpc_sync u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in (analog_compare),
    .sync_out (raw_sync)
  );

  // Powered-off core gives no result; bit parks at zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      compare_result <= `CMPC_RST_RESULT;
    end else begin
      compare_result <= comparator_power_on & (raw_sync ^ output_polarity);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Matches result reset so no false edge follows reset
      result_prev <= `CMPC_RST_RESULT;
    end else begin
      result_prev <= compare_result;
    end
  end

  assign rise_seen = compare_result & ~result_prev;
  assign fall_seen = ~compare_result & result_prev;

  always_comb begin
    unique case (irq_edge_select)
      cmpc_pkg::CMPC_EDGE_RISE: edge_hit = rise_seen;
      cmpc_pkg::CMPC_EDGE_FALL: edge_hit = fall_seen;
      cmpc_pkg::CMPC_EDGE_BOTH,
      cmpc_pkg::CMPC_EDGE_ANY:  edge_hit = rise_seen | fall_seen;
    endcase
  end

  // ----------------------------------------------------------------
  // Output pin, registered; enable low while driving
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      compare_output_pin_o    <= `CMPC_RST_PIN_OUT;
      compare_output_pin_oe_n <= `CMPC_RST_PIN_OE_N;
    end else begin
      compare_output_pin_o    <= compare_result;
      compare_output_pin_oe_n <= output_path_select;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flag and enable
  // ----------------------------------------------------------------
  // Edge wins over a software clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_flag <= `CMPC_RST_FLAG;
    end else if (edge_hit) begin
      irq_flag <= 1'b1;
    end else if (flag_write) begin
      irq_flag <= reg_wdata[`CMPC_BIT_FLAG];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_enable <= `CMPC_RST_ENABLE;
    end else if (flag_write) begin
      irq_enable <= reg_wdata[`CMPC_BIT_ENABLE];
    end
  end

  assign irq_request = irq_flag & irq_enable;

  // Only a fresh edge wakes; a flag preset before sleep blocks it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_request <= 1'b0;
    end else begin
      wake_request <= low_power_mode & edge_hit & ~irq_flag;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  assign control_value = {input_pin_select, comparator_power_on, output_polarity, compare_result,
                          output_path_select, irq_edge_select, hysteresis_on};

  always_comb begin
    next_rdata = 8'h00;
    if (reg_read) begin
      unique case (reg_addr)
        `CMPC_ADDR_CONTROL: next_rdata = control_value;
        `CMPC_ADDR_FLAG:    next_rdata = {6'h00, irq_enable, irq_flag};
        `CMPC_ADDR_PORT:    next_rdata = {6'h00, port_view};
        `CMPC_ADDR_SLEEP:   next_rdata = {7'h00, low_power_mode};
        default:            next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= `CMPC_RST_RDATA;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // cmpc_top

// ==== verification/cmpc_top_assertions.sv ====
`timescale 1ns/1ps
module cmpc_top_assertions (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       analog_power_on,
  input wire logic       analog_hysteresis_on,
  input wire logic       analog_inputs_connect,
  input wire logic [1:0] pull_high_request,
  input wire logic [1:0] pull_high_enable,
  input wire logic [1:0] port_function_enable,
  input wire logic       compare_output_pin_oe_n,
  input wire logic       low_power_mode,
  input wire logic       wake_request
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire ctl_wr = reg_write && (reg_addr == 4'h0);
  chk_pin_handover: assert property (port_function_enable == {2{~analog_inputs_connect}})
    else $error("port function not released");
  chk_pullup_drop: assert property (pull_high_enable == (pull_high_request & {2{~analog_inputs_connect}}))
    else $error("pull-high not dropped");
  chk_select_write: assert property (ctl_wr |=> analog_inputs_connect == $past(reg_wdata[7]))
    else $error("pin select not applied");
  chk_power_write: assert property (ctl_wr |=> analog_power_on == $past(reg_wdata[6]))
    else $error("power bit not applied");
  chk_hyst_write: assert property (ctl_wr |=> analog_hysteresis_on == $past(reg_wdata[0]))
    else $error("hysteresis bit not applied");
  chk_path_write: assert property (ctl_wr |=> ##1 compare_output_pin_oe_n == $past(reg_wdata[3], 2))
    else $error("output path not applied");
  chk_wake_cause: assert property (wake_request |-> $past(low_power_mode))
    else $error("wake outside low power");
  chk_wake_pulse: assert property (wake_request |=> !wake_request)
    else $error("wake longer than one cycle");
  // ----------------------------
  // Coverage
  // ----------------------------
  cov_wake: cover property (wake_request);
  cov_power: cover property (ctl_wr && reg_wdata[6]);
  cov_drive: cover property ($fell(compare_output_pin_oe_n));
endmodule // cmpc_top_assertions

// ==== verification/cmpc_analog_model.sv ====
`timescale 1ns/1ps
module cmpc_analog_model (
  input  wire logic clk_sys,
  input  wire logic power_on,
  input  wire logic connect,
  input  wire logic plus_above,
  output logic      analog_compare
);
  logic noise = 1'b0;
  // Unpowered core has no defined output, so it wanders
  always @(posedge clk_sys) noise <= ~noise;
  assign analog_compare = (power_on && connect) ? plus_above : noise;
endmodule // cmpc_analog_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, g); end end
module testbench;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [1:0] port_data = 2'b00, port_control = 2'b00, pull_high_request = 2'b10;
  logic [1:0] pull_high_enable, port_function_enable;
  logic       low_power_mode = 1'b0, plus_above = 1'b0, analog_compare, irq_request, wake_request;
  logic       analog_power_on, analog_hysteresis_on, analog_inputs_connect;
  logic       compare_output_pin_o, compare_output_pin_oe_n;
  int         errors = 0, checks_done = 0, wakes = 0;
  cmpc_top DUT (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .analog_compare,
    .analog_power_on, .analog_hysteresis_on, .analog_inputs_connect, .port_data, .port_control,
    .pull_high_request, .pull_high_enable, .port_function_enable, .compare_output_pin_o,
    .compare_output_pin_oe_n, .low_power_mode, .irq_request, .wake_request);
  cmpc_analog_model u_model (.clk_sys, .power_on(analog_power_on), .connect(analog_inputs_connect),
    .plus_above, .analog_compare);
  initial forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (wake_request === 1'b1) wakes <= wakes + 1;
  // ----------------------------
  // Bus tasks
  // ----------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    `CHK(n, e, reg_rdata)
  endtask
  // Sync plus edge logic needs six edges
  task automatic settle;
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  task automatic conclude;
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    conclude();
  end
  // ----------------------------
  // Main sequence
  // ----------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    `CHK("connect", 1'b1, analog_inputs_connect)
    `CHK("hyst", 1'b1, analog_hysteresis_on)
    rdc("ctrl_rst", 4'h0, 8'h81);
    rdc("unmapped", 4'hF, 8'h00);
    wr(4'hF, 8'h00);
    rdc("wr_ignored", 4'h0, 8'h81);
    wr(4'h0, 8'h41);
    #1;
    `CHK("pfe_io", 2'b11, port_function_enable)
    `CHK("phe_io", 2'b10, pull_high_enable)
    wr(4'h0, 8'hDF);
    settle();
    rdc("ctrl_ro", 4'h0, 8'hCF);
    `CHK("oe_int", 1'b1, compare_output_pin_oe_n)
    `CHK("pfe_cmp", 2'b00, port_function_enable)
    `CHK("phe_cmp", 2'b00, pull_high_enable)
    wr(4'h0, 8'hF7);
    settle();
    rdc("ctrl_inv", 4'h0, 8'hF7);
    `CHK("pin_o", 1'b1, compare_output_pin_o)
    `CHK("oe_pin", 1'b0, compare_output_pin_oe_n)
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, {5'b11000, 2'(c), 1'b0});
      settle();
      wr(4'h1, 8'h02);
      plus_above <= 1'b1;
      settle();
      rdc("rise", 4'h1, {6'h00, 1'b1, c != 1});
      `CHK("irq", c != 1, irq_request)
      wr(4'h1, 8'h02);
      settle();
      rdc("once", 4'h1, 8'h02);
      @(posedge clk_sys);
      plus_above <= 1'b0;
      settle();
      rdc("fall", 4'h1, {6'h00, 1'b1, c != 0});
    end
    @(posedge clk_sys);
    low_power_mode <= 1'b1;
    wr(4'h1, 8'h00);
    plus_above <= 1'b1;
    settle();
    `CHK("wake", 1, wakes)
    rdc("sleep_rd", 4'h3, 8'h01);
    wr(4'h1, 8'h01);
    plus_above <= 1'b0;
    settle();
    `CHK("no_wake", 1, wakes)
    `CHK("irq_off", 1'b0, irq_request)
    @(posedge clk_sys);
    low_power_mode <= 1'b0;
    port_data <= 2'b11;
    port_control <= 2'b01;
    rdc("port_cmp", 4'h2, 8'h02);
    wr(4'h0, 8'h80);
    rdc("port_off", 4'h2, 8'h03);
    `CHK("power", 1'b0, analog_power_on)
    // Mid-run reset must restore defaults and drop the flag
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdc("ctrl_rerst", 4'h0, 8'h81);
    rdc("flag_rerst", 4'h1, 8'h00);
    conclude();
  end
endmodule // testbench
bind cmpc_top cmpc_top_assertions u_chk (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_write, .analog_power_on,
  .analog_hysteresis_on, .analog_inputs_connect, .pull_high_request, .pull_high_enable, .port_function_enable,
  .compare_output_pin_oe_n, .low_power_mode, .wake_request);
